//--- fcd_pkg.sv
package fcd_pkg;

	// bus timing, figures in ns, counts derived from the 200 MHz clock
	localparam int FCD_CLK_PERIOD_NS = 5;
	localparam int FCD_T_SETUP_NS = 10;
	localparam int FCD_T_WP_NS = 35;
	localparam int FCD_T_WPH_NS = 30;
	localparam int FCD_T_ACC_NS = 70;
	localparam int FCD_SYNC_STAGES = 2;
	// least times round up, never below one cycle
	localparam int FCD_SETUP_CYC =
		(FCD_T_SETUP_NS + FCD_CLK_PERIOD_NS - 1) / FCD_CLK_PERIOD_NS;
	localparam int FCD_WP_CYC =
		(FCD_T_WP_NS + FCD_CLK_PERIOD_NS - 1) / FCD_CLK_PERIOD_NS;
	localparam int FCD_WPH_CYC =
		(FCD_T_WPH_NS + FCD_CLK_PERIOD_NS - 1) / FCD_CLK_PERIOD_NS;
	localparam int FCD_RD_CYC =
		(FCD_T_ACC_NS + FCD_CLK_PERIOD_NS - 1) / FCD_CLK_PERIOD_NS
		+ FCD_SYNC_STAGES;

	// widths
	localparam int FCD_AW = 21;
	localparam int FCD_DW = 16;

	// unlock addresses, word and byte mode
	localparam logic [20:0] FCD_U1_WORD = 21'h555;
	localparam logic [20:0] FCD_U2_WORD = 21'h2aa;
	localparam logic [20:0] FCD_U1_BYTE = 21'haaa;
	localparam logic [20:0] FCD_U2_BYTE = 21'h555;
	localparam logic [20:0] FCD_QRY_WORD = 21'h55;
	localparam logic [20:0] FCD_QRY_BYTE = 21'haa;
	localparam logic [20:0] FCD_ADDR_ANY = 21'h0;

	// command data bytes
	localparam logic [15:0] FCD_D_UNLOCK1 = 16'haa;
	localparam logic [15:0] FCD_D_UNLOCK2 = 16'h55;
	localparam logic [15:0] FCD_D_RESET = 16'hf0;
	localparam logic [15:0] FCD_D_AUTOSEL = 16'h90;
	localparam logic [15:0] FCD_D_QUERY = 16'h98;
	localparam logic [15:0] FCD_D_PROGRAM = 16'ha0;
	localparam logic [15:0] FCD_D_BYPASS = 16'h20;
	localparam logic [15:0] FCD_D_BYP_EXIT = 16'h0;
	localparam logic [15:0] FCD_D_ERASE_SETUP = 16'h80;
	localparam logic [15:0] FCD_D_CHIP_ERASE = 16'h10;
	localparam logic [15:0] FCD_D_SECT_ERASE = 16'h30;
	localparam logic [15:0] FCD_D_SUSPEND = 16'hb0;
	localparam logic [15:0] FCD_D_RESUME = 16'h30;

	// status bit positions on the data bus
	localparam int FCD_POLL_BIT = 7;
	localparam int FCD_LIMIT_BIT = 5;

	typedef enum logic [3:0] {
		FCD_OP_READ = 4'h0,
		FCD_OP_RESET = 4'h1,
		FCD_OP_AUTOSEL = 4'h2,
		FCD_OP_QUERY = 4'h3,
		FCD_OP_PROGRAM = 4'h4,
		FCD_OP_BYP_ENTER = 4'h5,
		FCD_OP_BYP_PROG = 4'h6,
		FCD_OP_BYP_EXIT = 4'h7,
		FCD_OP_CHIP_ERASE = 4'h8,
		FCD_OP_SECT_ERASE = 4'h9,
		FCD_OP_SECT_ADD = 4'ha,
		FCD_OP_SUSPEND = 4'hb,
		FCD_OP_RESUME = 4'hc,
		FCD_OP_POLL_ERASE = 4'hd
	} fcd_op_type;

	typedef enum logic [1:0] {
		FCD_CYC_END = 2'h0,
		FCD_CYC_WR = 2'h1,
		FCD_CYC_RD = 2'h2
	} fcd_kind_type;

	// one user order
	typedef struct packed {
		fcd_op_type op;
		logic [20:0] addr;
		logic [15:0] data;
		logic byte_mode;
		logic hold;
	} fcd_cmd_type;

	// one bus cycle of a sequence
	typedef struct packed {
		fcd_kind_type kind;
		logic [20:0] addr;
		logic [15:0] data;
	} fcd_cycle_type;

	// flash strobes, address and data drive
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [20:0] addr;
		logic [15:0] dq_out;
		logic dq_oe;
	} fcd_pins_type;

	localparam fcd_pins_type FCD_PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1,
		oe_n: 1'b1, addr: 21'h0, dq_out: 16'h0, dq_oe: 1'b0};

endpackage

//--- fcd_bus_cycle.sv
`timescale 1ns/10ps
module fcd_bus_cycle import fcd_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic is_write,
	input wire logic [20:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] flash_dq_in,
	output fcd_pins_type flash,
	output logic done,
	output logic [15:0] rdata
);

	typedef enum logic [1:0] {
		FCD_BC_IDLE = 2'h0,
		FCD_BC_SETUP = 2'h1,
		FCD_BC_STROBE = 2'h2,
		FCD_BC_HOLD = 2'h3
	} fcd_bc_phase_type;

	typedef struct packed {
		fcd_bc_phase_type phase;
		logic [7:0] cnt;
		logic wr;
		fcd_pins_type pins;
		logic done;
		logic [15:0] rdata;
		logic [15:0] sync1; // only the second stage reads this
		logic [15:0] sync2;
	} fcd_bc_state_type;

	fcd_bc_state_type r;
	fcd_bc_state_type next_r;

	////////////////////////////////////////////////////////////////////////
	// cycle sequencer: address first, strobe later, release in order
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		next_r.sync1 = flash_dq_in;
		next_r.sync2 = r.sync1;
		case (r.phase)
			FCD_BC_IDLE: begin
				if (start) begin
					// address and data settle before the strobe falls
					next_r.pins.addr = addr;
					next_r.pins.dq_out = wdata;
					next_r.pins.dq_oe = is_write;
					next_r.pins.ce_n = 1'b0;
					next_r.wr = is_write;
					next_r.cnt = 8'(FCD_SETUP_CYC - 1);
					next_r.phase = FCD_BC_SETUP;
				end
			end
			FCD_BC_SETUP: begin
				if (r.cnt == 8'h0) begin
					// write cycle or read cycle per step kind
					next_r.pins.we_n = ~r.wr;
					next_r.pins.oe_n = r.wr;
					next_r.cnt = r.wr ? 8'(FCD_WP_CYC - 1)
						: 8'(FCD_RD_CYC - 1);
					next_r.phase = FCD_BC_STROBE;
				end else begin
					next_r.cnt = r.cnt - 8'h1;
				end
			end
			FCD_BC_STROBE: begin
				if (r.cnt == 8'h0) begin
					// data stays driven past the rising edge
					next_r.pins.we_n = 1'b1;
					next_r.pins.oe_n = 1'b1;
					if (!r.wr) begin
						next_r.rdata = r.sync2;
					end
					next_r.cnt = 8'(FCD_WPH_CYC - 1);
					next_r.phase = FCD_BC_HOLD;
				end else begin
					next_r.cnt = r.cnt - 8'h1;
				end
			end
			FCD_BC_HOLD: begin
				if (r.cnt == 8'h0) begin
					// recovery also spaces back to back cycles
					next_r.pins.ce_n = 1'b1;
					next_r.pins.dq_oe = 1'b0;
					next_r.done = 1'b1;
					next_r.phase = FCD_BC_IDLE;
				end else begin
					next_r.cnt = r.cnt - 8'h1;
				end
			end
			default: begin
				next_r.phase = FCD_BC_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '{phase: FCD_BC_IDLE, cnt: 8'h0, wr: 1'b0,
				pins: FCD_PINS_IDLE, done: 1'b0, rdata: 16'h0,
				sync1: 16'h0, sync2: 16'h0};
		end else begin
			r <= next_r;
		end
	end

	assign flash = r.pins;
	assign done = r.done;
	assign rdata = r.rdata;

endmodule

//--- fcd_flash_ctrl.sv
`timescale 1ns/10ps
// Summary of operation
// - all cycles write, except reads
// - autoselect: two unlock writes and 90, then read
// - program: unlock, A0, then data
// - bypass: enter with 20, A0 plus data
// - erase: six writes, 10 or 30
// - take data from a later read
module fcd_flash_ctrl import fcd_pkg::*; #(
	parameter int POLL_MAX_READS = 1_000_000
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	input fcd_cmd_type cmd,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic rsp_fail,
	output fcd_pins_type flash,
	output logic flash_byte_n,
	input wire logic [15:0] flash_dq_in
);

	typedef enum logic [2:0] {
		FCD_ST_IDLE = 3'h0,
		FCD_ST_ISSUE = 3'h1,
		FCD_ST_WAIT = 3'h2,
		FCD_ST_POLL = 3'h3,
		FCD_ST_POLL_WAIT = 3'h4,
		FCD_ST_FINAL_WAIT = 3'h5,
		FCD_ST_FAIL_WAIT = 3'h6,
		FCD_ST_RESP = 3'h7
	} fcd_state_type;

	typedef struct packed {
		fcd_state_type state;
		fcd_cmd_type cmd;
		logic [2:0] step;
		logic [31:0] poll_cnt;
		logic limit_seen; // timing-limit bit seen once
		logic bus_start;
		logic bus_write;
		logic [20:0] bus_addr;
		logic [15:0] bus_data;
		logic cmd_ready;
		logic rsp_valid;
		logic [15:0] rsp_data;
		logic rsp_fail;
		logic byte_n;
	} fcd_ctrl_state_type;

	fcd_ctrl_state_type r;
	fcd_ctrl_state_type next_r;
	logic bus_done;
	logic [15:0] bus_rdata;

	////////////////////////////////////////////////////////////////////////
	// step table: the bus cycle at position idx of an order
	function automatic fcd_cycle_type seq_step(input fcd_cmd_type c,
		input logic [2:0] idx);
		fcd_cycle_type y;
		logic [20:0] u1;
		logic [20:0] u2;
		logic [15:0] d;
		y = '{kind: FCD_CYC_END, addr: FCD_ADDR_ANY, data: 16'h0};
		u1 = c.byte_mode ? FCD_U1_BYTE : FCD_U1_WORD;
		u2 = c.byte_mode ? FCD_U2_BYTE : FCD_U2_WORD;
		// byte mode carries no upper data byte
		d = c.byte_mode ? {8'h0, c.data[7:0]} : c.data;
		case (c.op)
			FCD_OP_READ: begin
				if (idx == 3'h0) begin
					y = '{FCD_CYC_RD, c.addr, 16'h0};
				end
			end
			FCD_OP_RESET: begin
				if (idx == 3'h0) begin
					y = '{FCD_CYC_WR, FCD_ADDR_ANY, FCD_D_RESET};
				end
			end
			FCD_OP_QUERY: begin
				if (idx == 3'h0) begin
					y = '{FCD_CYC_WR, c.byte_mode ? FCD_QRY_BYTE
						: FCD_QRY_WORD, FCD_D_QUERY};
				end
			end
			FCD_OP_BYP_PROG: begin
				// two writes inside bypass mode
				case (idx)
					3'h0: y = '{FCD_CYC_WR, FCD_ADDR_ANY, FCD_D_PROGRAM};
					3'h1: y = '{FCD_CYC_WR, c.addr, d};
					default: y.kind = FCD_CYC_END;
				endcase
			end
			FCD_OP_BYP_EXIT: begin
				case (idx)
					3'h0: y = '{FCD_CYC_WR, FCD_ADDR_ANY, FCD_D_AUTOSEL};
					3'h1: y = '{FCD_CYC_WR, FCD_ADDR_ANY,
						FCD_D_BYP_EXIT};
					default: y.kind = FCD_CYC_END;
				endcase
			end
			FCD_OP_SECT_ADD: begin
				if (idx == 3'h0) begin
					// extra sector inside the open window
					y = '{FCD_CYC_WR, c.addr, FCD_D_SECT_ERASE};
				end
			end
			FCD_OP_SUSPEND: begin
				if (idx == 3'h0) begin
					y = '{FCD_CYC_WR, FCD_ADDR_ANY, FCD_D_SUSPEND};
				end
			end
			FCD_OP_RESUME: begin
				if (idx == 3'h0) begin
					y = '{FCD_CYC_WR, FCD_ADDR_ANY, FCD_D_RESUME};
				end
			end
			FCD_OP_POLL_ERASE: begin
				y.kind = FCD_CYC_END;
			end
			default: begin
				// unlocked orders share the two unlock writes
				case (idx)
					3'h0: y = '{FCD_CYC_WR, u1, FCD_D_UNLOCK1};
					3'h1: y = '{FCD_CYC_WR, u2, FCD_D_UNLOCK2};
					3'h2: begin
						y.kind = FCD_CYC_WR;
						y.addr = u1;
						case (c.op)
							FCD_OP_AUTOSEL: y.data = FCD_D_AUTOSEL;
							FCD_OP_PROGRAM: y.data = FCD_D_PROGRAM;
							FCD_OP_BYP_ENTER: y.data = FCD_D_BYPASS;
							default: y.data = FCD_D_ERASE_SETUP;
						endcase
					end
					3'h3: begin
						case (c.op)
							// fourth autoselect cycle reads
							FCD_OP_AUTOSEL: y = '{FCD_CYC_RD, c.addr, 16'h0};
							FCD_OP_PROGRAM: y = '{FCD_CYC_WR, c.addr, d};
							FCD_OP_BYP_ENTER: y.kind = FCD_CYC_END;
							default: y = '{FCD_CYC_WR, u1, FCD_D_UNLOCK1};
						endcase
					end
					3'h4: begin
						if (c.op == FCD_OP_CHIP_ERASE ||
							c.op == FCD_OP_SECT_ERASE) begin
							y = '{FCD_CYC_WR, u2, FCD_D_UNLOCK2};
						end
					end
					3'h5: begin
						if (c.op == FCD_OP_CHIP_ERASE) begin
							y = '{FCD_CYC_WR, u1, FCD_D_CHIP_ERASE};
						end else if (c.op == FCD_OP_SECT_ERASE) begin
							y = '{FCD_CYC_WR, c.addr,
								FCD_D_SECT_ERASE};
						end
					end
					default: y.kind = FCD_CYC_END;
				endcase
			end
		endcase
		return y;
	endfunction

	// orders that end by polling an embedded algorithm
	function automatic logic needs_poll(input fcd_cmd_type c);
		case (c.op)
			FCD_OP_PROGRAM, FCD_OP_BYP_PROG: return 1'b1;
			FCD_OP_CHIP_ERASE, FCD_OP_SECT_ERASE,
			FCD_OP_SECT_ADD: return ~c.hold;
			FCD_OP_POLL_ERASE: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// erase polls for a 1, programs for the true data bit
	function automatic logic poll_target(input fcd_cmd_type c);
		if (c.op == FCD_OP_PROGRAM || c.op == FCD_OP_BYP_PROG) begin
			return c.data[FCD_POLL_BIT];
		end
		return 1'b1;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// order sequencer and polling loop
	always_comb begin
		fcd_cycle_type cyc;
		cyc = seq_step(r.cmd, r.step);
		next_r = r;
		next_r.bus_start = 1'b0;
		next_r.rsp_valid = 1'b0;
		case (r.state)
			FCD_ST_IDLE: begin
				next_r.cmd_ready = 1'b1;
				if (cmd_valid && r.cmd_ready) begin
					next_r.cmd = cmd;
					next_r.byte_n = ~cmd.byte_mode;
					next_r.step = 3'h0;
					next_r.poll_cnt = 32'h0;
					next_r.limit_seen = 1'b0;
					next_r.rsp_fail = 1'b0;
					next_r.cmd_ready = 1'b0;
					next_r.state = FCD_ST_ISSUE;
				end
			end
			FCD_ST_ISSUE: begin
				if (cyc.kind == FCD_CYC_END) begin
					// status is valid once the last write has risen
					next_r.state = needs_poll(r.cmd) ? FCD_ST_POLL
						: FCD_ST_RESP;
				end else begin
					next_r.bus_start = 1'b1;
					next_r.bus_write = (cyc.kind == FCD_CYC_WR);
					next_r.bus_addr = cyc.addr;
					next_r.bus_data = cyc.data;
					next_r.state = FCD_ST_WAIT;
				end
			end
			FCD_ST_WAIT: begin
				if (bus_done) begin
					if (!r.bus_write) begin
						next_r.rsp_data = bus_rdata;
					end
					next_r.step = r.step + 3'h1;
					next_r.state = FCD_ST_ISSUE;
				end
			end
			FCD_ST_POLL: begin
				// poll at the program location or erased sector
				next_r.bus_start = 1'b1;
				next_r.bus_write = 1'b0;
				next_r.bus_addr = r.cmd.addr;
				next_r.poll_cnt = r.poll_cnt + 32'h1;
				next_r.state = FCD_ST_POLL_WAIT;
			end
			FCD_ST_POLL_WAIT: begin
				if (bus_done) begin
					next_r.bus_start = 1'b1;
					if (bus_rdata[FCD_POLL_BIT] == poll_target(r.cmd)) begin
						// other bits may lag: read once more
						next_r.state = FCD_ST_FINAL_WAIT;
					end else if ((bus_rdata[FCD_LIMIT_BIT] && r.limit_seen)
						|| r.poll_cnt == 32'(POLL_MAX_READS)) begin
						// limit bit on two reads in a row, or read budget spent: failed, reset
						next_r.bus_write = 1'b1;
						next_r.bus_addr = FCD_ADDR_ANY;
						next_r.bus_data = FCD_D_RESET;
						next_r.state = FCD_ST_FAIL_WAIT;
					end else begin
						// protected targets just keep us polling a while
						next_r.limit_seen = bus_rdata[FCD_LIMIT_BIT];
						next_r.bus_start = 1'b0;
						next_r.state = FCD_ST_POLL;
					end
				end
			end
			FCD_ST_FINAL_WAIT: begin
				if (bus_done) begin
					next_r.rsp_data = bus_rdata;
					next_r.state = FCD_ST_RESP;
				end
			end
			FCD_ST_FAIL_WAIT: begin
				if (bus_done) begin
					next_r.rsp_fail = 1'b1;
					next_r.state = FCD_ST_RESP;
				end
			end
			FCD_ST_RESP: begin
				next_r.rsp_valid = 1'b1;
				next_r.cmd_ready = 1'b1;
				next_r.state = FCD_ST_IDLE;
			end
			default: begin
				next_r.state = FCD_ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '{state: FCD_ST_IDLE, cmd: '0, step: 3'h0,
				poll_cnt: 32'h0, limit_seen: 1'b0, bus_start: 1'b0,
				bus_write: 1'b0, bus_addr: 21'h0, bus_data: 16'h0,
				cmd_ready: 1'b0, rsp_valid: 1'b0, rsp_data: 16'h0,
				rsp_fail: 1'b0, byte_n: 1'b1};
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin timing engine
	fcd_bus_cycle u_bus (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(r.bus_start),
		.is_write(r.bus_write),
		.addr(r.bus_addr),
		.wdata(r.bus_data),
		.flash_dq_in(flash_dq_in),
		.flash(flash),
		.done(bus_done),
		.rdata(bus_rdata)
	);

	assign cmd_ready = r.cmd_ready;
	assign rsp_valid = r.rsp_valid;
	assign rsp_data = r.rsp_data;
	assign rsp_fail = r.rsp_fail;
	assign flash_byte_n = r.byte_n;

endmodule

//--- fcd_flash_ctrl_sva.sv
`timescale 1ns/10ps
module fcd_flash_ctrl_sva import fcd_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input fcd_pins_type flash,
	input wire logic flash_byte_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// write strobe pulse, then the gap before the next select
	sequence we_pulse;
		!flash.we_n [*7] ##1 flash.we_n;
	endsequence
	sequence idle_gap;
		flash.ce_n [*2];
	endsequence
	we_width_a: assert property ($fell(flash.we_n) |-> we_pulse)
		else $error("write strobe width wrong");
	we_setup_a: assert property ($fell(flash.we_n) |->
		$past(flash.ce_n, 2) == 1'b0 && flash.dq_oe)
		else $error("write strobe without setup");
	addr_hold_a: assert property (!flash.ce_n |=>
		flash.ce_n || $stable(flash.addr)) else $error("address moved");
	data_hold_a: assert property (!flash.we_n |=>
		$stable(flash.dq_out) && flash.dq_oe) else $error("data moved");
	strobe_excl_a: assert property (flash.we_n || flash.oe_n)
		else $error("read and write strobes together");
	drive_sel_a: assert property (flash.dq_oe |->
		!flash.ce_n && flash.oe_n) else $error("data driven off cycle");
	upper_byte_a: assert property (flash.dq_oe && !flash_byte_n |->
		flash.dq_out[15:8] == 8'h00) else $error("upper byte driven");
	cycle_gap_a: assert property ($rose(flash.ce_n) |-> idle_gap)
		else $error("cycles too close");
	take_once_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
		else $error("order taken twice");
	rsp_pulse_a: assert property (rsp_valid |-> cmd_ready ##1 !rsp_valid)
		else $error("answer pulse wrong");
endmodule
bind fcd_flash_ctrl fcd_flash_ctrl_sva u_sva (.clk(clk), .sys_rst(sys_rst),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
	.flash(flash), .flash_byte_n(flash_byte_n));

//--- fcd_flash_model.sv
`timescale 1ns/10ps
module fcd_flash_model import fcd_pkg::*; #(
	parameter logic [15:0] MAKER = 16'h005a, // arbitrary value
	parameter logic [5:0] PROT = 6'h1f, // the one locked sector
	parameter int PROG_CYC = 100,
	parameter int PROT_CYC = 200, // about 1 us
	parameter int ERASE_CYC = 600,
	parameter int WIN_CYC = 200 // window for further sectors
) (
	input wire logic clk,
	input fcd_pins_type flash,
	input wire logic byte_n,
	output logic [15:0] dq_in
);
	logic [15:0] mem [logic [20:0]], cp [logic [20:0]]; // blank reads ones
	logic [20:0] la;
	logic [63:0] es = 64'h0; // sectors picked for erase
	logic [15:0] pv, rv = 16'h0000;
	logic [11:0] u1, u2, a;
	logic [7:0] d;
	int st = 0, busy = 0, ers = 0;
	logic byp = 0, asel = 0, qry = 0, susp = 0, pgm = 0, tog = 0;
	assign u1 = byte_n ? 12'h555 : 12'haaa;
	assign u2 = byte_n ? 12'h2aa : 12'h555;
	// released bus shows the inverse, so no stale value passes
	assign dq_in = (!flash.ce_n && !flash.oe_n) ? rv : ~rv;
	always @(negedge flash.we_n) la = flash.addr;
	// internal algorithm timer, frozen while suspended
	always @(posedge clk) if (busy > 0 && !susp) begin
		busy = busy - 1;
		if (busy == 0 && ers == 1) mem.delete();
		if (busy == 0 && ers == 2) begin
			cp = mem;
			// locked sectors in the set are left as they are
			foreach (cp[k])
				if (es[k[20:15]] && k[20:15] != PROT)
					mem.delete(k);
		end
		if (busy == 0) ers = 0;
	end
	// read cycles: status while busy and not suspended, else codes or array
	always @(negedge flash.oe_n) if (!flash.ce_n) begin
		if (busy > 0 && !susp) begin
			tog = ~tog;
			rv = {8'h00, pgm ? ~pv[7] : 1'b0, tog, 6'h00};
		end else if (asel)
			rv = flash.addr[7:0] == 8'h00 ? MAKER : {15'h0, flash.addr[20:15]
				== PROT && flash.addr[7:0] == (byte_n ? 8'h02 : 8'h04)};
		else
			rv = mem.exists(flash.addr) ? mem[flash.addr] : 16'hffff;
	end
	// command decoder on each completed write cycle
	always @(posedge flash.we_n) if (!flash.ce_n) begin
		d = flash.dq_out[7:0];
		a = la[11:0];
		if (busy > 0 && !susp) begin
			if (d == 8'hb0 && ers == 2) susp = 1;
			else if (d == 8'h30 && ers == 2 &&
				busy > ERASE_CYC - WIN_CYC) begin
				// another sector restarts the window
				es[la[20:15]] = 1'b1;
				busy = ERASE_CYC;
			end
		end else if (susp && st == 0 && d == 8'h30) susp = 0;
		else if (st == 3) begin
			// the data cycle is never a command, even if it reads F0
			st = 0;
			pv = flash.dq_out;
			pgm = 1;
			busy = la[20:15] == PROT ? PROT_CYC : PROG_CYC;
			if (la[20:15] != PROT) mem[la] = pv;
		end else if (d == 8'hf0) begin
			st = 0;
			byp = 0;
			asel = 0;
			qry = 0;
		end else if (byp && d == 8'ha0) st = 3;
		else if (byp) begin
			byp = !(st == 7 && d == 8'h00);
			st = d == 8'h90 ? 7 : 0;
		end else if (d == 8'h98 && a == (byte_n ? 12'h055 : 12'h0aa)) qry = 1;
		else if (st == 0 || st == 4) st = d == 8'haa && a == u1 ? st + 1 : 0;
		else if (st == 1 || st == 5) st = d == 8'h55 && a == u2 ? st + 1 : 0;
		else if (st == 2) begin
			st = 0;
			if (d == 8'ha0) st = 3;
			if (d == 8'h90) asel = 1;
			if (d == 8'h20) byp = 1;
			if (d == 8'h80) st = 4;
		end else begin
			ers = st == 6 && d == 8'h10 ? 1 : st == 6 && d == 8'h30 ? 2 : 0;
			es = 64'h0;
			es[la[20:15]] = 1'b1;
			pgm = 0;
			busy = ers != 0 ? ERASE_CYC : 0;
			st = 0;
		end
	end
endmodule

//--- fcd_flash_ctrl_tb_top.sv
`timescale 1ns/10ps
module fcd_flash_ctrl_tb_top import fcd_pkg::*;;
	localparam logic [5:0] PROT = 6'h1f;
	localparam logic [15:0] MAKER = 16'h005a; // arbitrary value
	logic clk = 0;
	logic sys_rst = 1;
	logic cmd_valid = 0;
	fcd_cmd_type cmd = '0;
	logic cmd_ready, rsp_valid, rsp_fail, byte_n;
	logic [15:0] rsp_data, dq_in, exp_d;
	logic [20:0] loc;
	fcd_pins_type flash;
	int num_errors = 0;
	int checked = 0;
	fcd_flash_ctrl #(.POLL_MAX_READS(64)) dut (.clk(clk), .sys_rst(sys_rst),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_fail(rsp_fail),
		.flash(flash), .flash_byte_n(byte_n), .flash_dq_in(dq_in));
	fcd_flash_model #(.MAKER(MAKER), .PROT(PROT)) u_flash (.clk(clk),
		.flash(flash), .byte_n(byte_n), .dq_in(dq_in));
	initial forever #2.5 clk = ~clk;
	////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		chk_data({15'h0, got}, {15'h0, exp});
	endtask
	// byte mode leaves the upper half of a written value clear
	function automatic logic [15:0] fit(input logic [15:0] v, input logic b);
		return b ? {8'h00, v[7:0]} : v;
	endfunction
	// one order: hold valid until taken, then wait for the answer
	task automatic run(input fcd_op_type op, input logic [20:0] a,
		input logic [15:0] d, input logic bm, input logic h);
		int n;
		n = 0;
		cmd_valid <= 1'b1;
		cmd <= '{op: op, addr: a, data: d, byte_mode: bm, hold: h};
		do @(posedge clk); while (!cmd_ready && ++n < 50);
		cmd_valid <= 1'b0;
		// an order never taken counts as a timeout too
		if (n >= 50)
			n = 20000;
		do @(posedge clk); while (!rsp_valid && ++n < 20000);
		if (n >= 20000) begin
			num_errors++;
			end_sim;
		end
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(83391));
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		run(FCD_OP_RESET, 21'h0, 16'h0, 1'b0, 1'b0);
		chk_flag(rsp_fail, 1'b0);
		// shortcut mode, then its exit
		loc = {6'h02, 15'($urandom)};
		exp_d = 16'($urandom);
		run(FCD_OP_BYP_ENTER, 21'h0, 16'h0, 1'b0, 1'b0);
		run(FCD_OP_BYP_PROG, loc, exp_d, 1'b0, 1'b0);
		chk_data(rsp_data, exp_d);
		run(FCD_OP_BYP_EXIT, 21'h0, 16'h0, 1'b0, 1'b0);
		// word then byte width: unlock addresses must follow
		for (int i = 0; i < 2; i++) begin
			loc[14:0] = 15'($urandom);
			exp_d = 16'($urandom);
			run(FCD_OP_PROGRAM, loc, exp_d, i[0], 1'b0);
			run(FCD_OP_READ, loc, 16'h0, i[0], 1'b0);
			chk_data(rsp_data, fit(exp_d, i[0]));
		end
		repeat (4) begin
			loc = {6'(3 + $urandom % 28), 15'($urandom)};
			exp_d = 16'($urandom);
			run(FCD_OP_PROGRAM, loc, exp_d, 1'b0, 1'b0);
			chk_data(rsp_data, exp_d);
			run(FCD_OP_READ, loc, 16'h0, 1'b0, 1'b0);
			chk_data(rsp_data, exp_d);
		end
		run(FCD_OP_AUTOSEL, 21'h0, 16'h0, 1'b0, 1'b0);
		chk_data(rsp_data, MAKER);
		run(FCD_OP_AUTOSEL, {PROT, 15'h0002}, 16'h0, 1'b0, 1'b0);
		chk_data(rsp_data, 16'h0001);
		run(FCD_OP_AUTOSEL, {6'h03, 15'h0002}, 16'h0, 1'b0, 1'b0);
		chk_data(rsp_data, 16'h0000);
		run(FCD_OP_QUERY, 21'h0, 16'h0, 1'b0, 1'b0);
		chk_flag(u_flash.qry, 1'b1);
		run(FCD_OP_RESET, 21'h0, 16'h0, 1'b0, 1'b0);
		chk_flag(u_flash.qry, 1'b0);
		// locked sector: poll never matches, data unchanged
		run(FCD_OP_PROGRAM, {PROT, 15'h0010}, 16'h0012, 1'b0, 1'b0);
		chk_flag(rsp_fail, 1'b1);
		run(FCD_OP_READ, {PROT, 15'h0010}, 16'h0, 1'b0, 1'b0);
		chk_data(rsp_data, 16'hffff);
		// sector erase, suspended for a read and codes, resumed
		run(FCD_OP_PROGRAM, 21'h10004, 16'h1234, 1'b0, 1'b0);
		run(FCD_OP_SECT_ERASE, 21'h10000, 16'h0, 1'b0, 1'b1);
		run(FCD_OP_SUSPEND, 21'h0, 16'h0, 1'b0, 1'b0);
		run(FCD_OP_READ, loc, 16'h0, 1'b0, 1'b0);
		chk_data(rsp_data, exp_d);
		run(FCD_OP_AUTOSEL, 21'h0, 16'h0, 1'b0, 1'b0);
		chk_data(rsp_data, MAKER);
		run(FCD_OP_RESET, 21'h0, 16'h0, 1'b0, 1'b0);
		run(FCD_OP_RESUME, 21'h0, 16'h0, 1'b0, 1'b0);
		run(FCD_OP_POLL_ERASE, 21'h10004, 16'h0, 1'b0, 1'b0);
		chk_data(rsp_data, 16'hffff);
		run(FCD_OP_READ, loc, 16'h0, 1'b0, 1'b0);
		chk_data(rsp_data, exp_d);
		run(FCD_OP_CHIP_ERASE, 21'h0, 16'h0, 1'b0, 1'b0);
		chk_data(rsp_data, 16'hffff);
		run(FCD_OP_READ, loc, 16'h0, 1'b0, 1'b0);
		chk_data(rsp_data, 16'hffff);
		// low byte F0 as program data must not act as a reset
		run(FCD_OP_PROGRAM, 21'h30008, 16'h0ff0, 1'b0, 1'b0);
		chk_data(rsp_data, 16'h0ff0);
		run(FCD_OP_PROGRAM, 21'h20008, 16'h5a5a, 1'b0, 1'b0);
		run(FCD_OP_PROGRAM, 21'h28008, 16'h3c3c, 1'b0, 1'b0);
		// two sectors in one window, polled at the added one
		run(FCD_OP_SECT_ERASE, 21'h20000, 16'h0, 1'b0, 1'b1);
		run(FCD_OP_SECT_ADD, 21'h30000, 16'h0, 1'b0, 1'b0);
		chk_data(rsp_data, 16'hffff);
		run(FCD_OP_READ, 21'h20008, 16'h0, 1'b0, 1'b0);
		chk_data(rsp_data, 16'hffff);
		run(FCD_OP_READ, 21'h28008, 16'h0, 1'b0, 1'b0);
		chk_data(rsp_data, 16'h3c3c);
		end_sim;
	end
endmodule
